// [bench/crbsc_ctrl_sva.sv]
// Checker for the buffer handoff interface state control.
// Assumes it is bound to crbsc_ctrl and sees only its ports.
`timescale 1ns/1ps
module crbsc_ctrl_sva
   import crbsc_pkg::*;
(
   // Clock and reset
   input wire logic         clock_in,
   input wire logic         rst_in,
   // Requests
   input wire logic         ready_request_in,
   input wire logic         idle_request_in,
   input wire logic         locality_change_in,
   input wire logic         launch_wr_in,
   input wire logic [31:0]  launch_wdata_in,
   input wire logic         cmd_done_in,
   input wire crbsc_acc_s   host_acc_in,
   // Answers and status
   input wire logic         host_ack_out,
   input wire logic         host_err_out,
   input wire logic [31:0]  host_rdata_out,
   input wire logic         idle_status_flag_out,
   input wire logic [31:0]  launch_field_out,
   input wire crbsc_state_e state_out,
   input wire logic         cmd_run_out
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // No request of higher priority than launch or buffer write
   sequence s_quiet;
      !locality_change_in && !idle_request_in && !ready_request_in;
   endsequence
   sequence s_launch;
      launch_wr_in && launch_wdata_in == LAUNCH_GO && state_out == CRBSC_RECEPTION ##0 s_quiet;
   endsequence
   sequence s_base_wr;
      host_acc_in.valid && host_acc_in.write && host_acc_in.addr == BUF_BASE && host_acc_in.size == 3'h4;
   endsequence

   property p_launch;
      s_launch |=> state_out == CRBSC_EXECUTION && launch_field_out == LAUNCH_GO && cmd_run_out;
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not start execution");
   property p_exec_end;
      state_out == CRBSC_EXECUTION && !locality_change_in |=>
         $past(cmd_done_in) ? state_out == CRBSC_COMPLETE && launch_field_out == LAUNCH_CLEAR && !cmd_run_out
                            : state_out == CRBSC_EXECUTION;
   endproperty
   a_exec_end: assert property (p_exec_end) else $error("execution left or held wrongly");
   property p_launch_ign;
      launch_wr_in && !host_acc_in.valid && state_out inside {CRBSC_IDLE, CRBSC_READY, CRBSC_COMPLETE} ##0 s_quiet
         |=> $stable(state_out);
   endproperty
   a_launch_ign: assert property (p_launch_ign) else $error("launch acted outside reception");
   property p_first_wr;
      state_out == CRBSC_READY && !launch_wr_in ##0 s_base_wr ##0 s_quiet |=> state_out == CRBSC_RECEPTION;
   endproperty
   a_first_wr: assert property (p_first_wr) else $error("base write did not start reception");
   property p_off_base;
      state_out == CRBSC_READY && host_acc_in.valid && host_acc_in.write && host_acc_in.addr != BUF_BASE ##0 s_quiet
         |=> state_out == CRBSC_READY;
   endproperty
   a_off_base: assert property (p_off_base) else $error("write off base left ready");
   property p_answer;
      host_acc_in.valid |=> host_ack_out != host_err_out;
   endproperty
   a_answer: assert property (p_answer) else $error("access not answered once");
   property p_rd_ignored;
      host_acc_in.valid && !host_acc_in.write && state_out != CRBSC_COMPLETE
         |=> host_ack_out && host_rdata_out == 32'h0000_0000;
   endproperty
   a_rd_ignored: assert property (p_rd_ignored) else $error("read answered outside completion");
   property p_go_idle;
      idle_request_in && !locality_change_in && state_out inside {CRBSC_RECEPTION, CRBSC_COMPLETE}
         |=> state_out == CRBSC_IDLE && idle_status_flag_out;
   endproperty
   a_go_idle: assert property (p_go_idle) else $error("idle request did not reach idle");
   property p_ready;
      ready_request_in && !idle_request_in && !locality_change_in && state_out == CRBSC_IDLE
         |=> state_out == CRBSC_READY && !idle_status_flag_out;
   endproperty
   a_ready: assert property (p_ready) else $error("ready request not taken");
   property p_locality;
      locality_change_in |=> state_out == CRBSC_IDLE && idle_status_flag_out && launch_field_out == LAUNCH_CLEAR
                             && !cmd_run_out;
   endproperty
   a_locality: assert property (p_locality) else $error("locality change did not reach idle");
endmodule

bind crbsc_ctrl crbsc_ctrl_sva chk_u (.*);

// [bench/crbsc_engine_model.sv]
// Behavioural command engine: writes one response word, then signals done.
// Assumes the run and cancel levels of crbsc_ctrl on the same clock.
`timescale 1ns/1ps
module crbsc_engine_model
   import crbsc_pkg::*;
#(
   parameter int          DELAY    = 20,
   parameter logic [31:0] RESP     = 32'h600D_0001,
   parameter logic [31:0] RESP_CAN = 32'h600D_00CA
)(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_in,
   // Controller side
   input  wire logic run_in,
   input  wire logic cancel_in,
   output logic      done_out,
   output crbsc_acc_s acc_out
);
   // ************************************************************
   // Run sequence
   // ************************************************************
   int cnt_q;
   always_ff @(posedge clock_in) begin
      acc_out  <= '0;
      done_out <= 1'b0;
      if (rst_in || !run_in) begin
         cnt_q <= 0;
      end else if (cnt_q <= DELAY) begin
         // Cancel cuts the run short but still leaves a response
         cnt_q <= (cancel_in && cnt_q < DELAY - 1) ? DELAY - 1 : cnt_q + 1;
         if (cnt_q == DELAY - 1) begin
            acc_out <= '{1'b1, 1'b1, BUF_BASE, 3'h4, cancel_in ? RESP_CAN : RESP};
         end
         done_out <= (cnt_q == DELAY);
      end
   end
endmodule

// [bench/tb.sv]
// Self-checking bench of crbsc_ctrl with the engine model at its far side.
// Assumes a 100 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", n, e, a); end end
module tb
   import crbsc_pkg::*;
;
   localparam logic [4:0] LOC = 5'h10, GOI = 5'h08, RDY = 5'h04, LCH = 5'h02, ABT = 5'h01;
   localparam logic [31:0] RESP = 32'h600D_0001, RESP_CAN = 32'h600D_00CA;
   logic clock_in = 1'b0, rst_in = 1'b1;
   logic locality_change_in = 1'b0, idle_request_in = 1'b0, ready_request_in = 1'b0;
   logic launch_wr_in = 1'b0, abort_wr_in = 1'b0, cmd_fatal_in = 1'b0;
   logic [31:0] launch_wdata_in = '0, abort_wdata_in = '0, host_rdata_out, eng_rdata_out;
   logic [31:0] launch_field_out, abort_command_field_out;
   logic host_ack_out, host_err_out, idle_status_flag_out, fatal_error_flag_out;
   logic cmd_run_out, cmd_cancel_out, cmd_done_in;
   logic [PTR_W-1:0] cmd_len_out;
   crbsc_acc_s host_acc_in = '0, eng_acc_in;
   crbsc_state_e state_out;
   int n_fail = 0, check_count = 0;

   always #5 clock_in = ~clock_in;

   crbsc_ctrl dut_u (.clock_in(clock_in), .rst_in(rst_in), .ready_request_in(ready_request_in),
      .idle_request_in(idle_request_in), .locality_change_in(locality_change_in), .launch_wr_in(launch_wr_in),
      .launch_wdata_in(launch_wdata_in), .abort_wr_in(abort_wr_in), .abort_wdata_in(abort_wdata_in),
      .host_acc_in(host_acc_in), .host_ack_out(host_ack_out), .host_err_out(host_err_out),
      .host_rdata_out(host_rdata_out), .idle_status_flag_out(idle_status_flag_out),
      .fatal_error_flag_out(fatal_error_flag_out), .launch_field_out(launch_field_out),
      .abort_command_field_out(abort_command_field_out), .state_out(state_out), .cmd_run_out(cmd_run_out),
      .cmd_cancel_out(cmd_cancel_out), .cmd_len_out(cmd_len_out), .cmd_done_in(cmd_done_in),
      .cmd_fatal_in(cmd_fatal_in), .eng_acc_in(eng_acc_in), .eng_rdata_out(eng_rdata_out));
   crbsc_engine_model #(.DELAY(20), .RESP(RESP), .RESP_CAN(RESP_CAN)) eng_u (.clock_in(clock_in),
      .rst_in(rst_in), .run_in(cmd_run_out), .cancel_in(cmd_cancel_out), .done_out(cmd_done_in),
      .acc_out(eng_acc_in));

   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One-cycle request pulse: {locality, idle, ready, launch, abort}
   task automatic req(input logic [4:0] m, input logic [31:0] d);
      @(posedge clock_in);
      {locality_change_in, idle_request_in, ready_request_in, launch_wr_in, abort_wr_in} <= m;
      launch_wdata_in <= d;
      abort_wdata_in  <= d;
      @(posedge clock_in);
      {locality_change_in, idle_request_in, ready_request_in, launch_wr_in, abort_wr_in} <= 5'h00;
      #1;
   endtask
   // Answer er is {err, ack}, checked the cycle after the request
   task automatic acc(input logic w, input logic [11:0] a, input logic [2:0] s, input logic [31:0] wd,
                      input logic [1:0] er, input logic [31:0] rd, input string n);
      @(posedge clock_in);
      host_acc_in <= '{1'b1, w, a, s, wd};
      @(posedge clock_in);
      host_acc_in <= '0;
      #1;
      `CHK(n, er, {host_err_out, host_ack_out})
      if (!w) `CHK(n, rd, host_rdata_out)
   endtask
   task automatic st(input crbsc_state_e s, input string n);
      `CHK(n, s, state_out)
      `CHK(n, (s == CRBSC_IDLE), idle_status_flag_out)
   endtask
   task automatic wait_st(input crbsc_state_e s);
      int i;
      i = 0;
      while (state_out !== s && i < 200) begin
         @(posedge clock_in);
         #1;
         i++;
      end
      if (i == 200) begin
         n_fail++;
         $display("[ERR] state wait expected %h seen %h", s, state_out);
         end_sim();
      end
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      #1;
      st(CRBSC_IDLE, "reset state");
      `CHK("reset launch", LAUNCH_RESET, launch_field_out)
      `CHK("reset abort", ABORT_RESET, abort_command_field_out)
      `CHK("reset fatal", FATAL_RESET, fatal_error_flag_out)
      acc(1'b1, 12'h000, 3'h4, 32'h0, 2'b01, 32'h0, "idle write");
      acc(1'b0, 12'h000, 3'h4, 32'h0, 2'b01, 32'h0, "idle read");
      req(LCH, LAUNCH_GO);
      st(CRBSC_IDLE, "idle launch");
      req(RDY, 32'h0);
      st(CRBSC_READY, "ready");
      $display("test idle_ready done");
      acc(1'b1, 12'h004, 3'h4, 32'h0, 2'b01, 32'h0, "off base write");
      st(CRBSC_READY, "off base state");
      acc(1'b1, 12'h000, 3'h4, 32'h1122_3344, 2'b01, 32'h0, "first write");
      st(CRBSC_RECEPTION, "reception");
      acc(1'b1, 12'h004, 3'h3, 32'h0, 2'b01, 32'h0, "size 3 write");
      acc(1'b1, 12'h008, 3'h4, 32'h0, 2'b01, 32'h0, "gap write");
      `CHK("len dropped", 13'h0004, cmd_len_out)
      acc(1'b1, 12'h004, 3'h2, 32'h0, 2'b01, 32'h0, "next write");
      `CHK("len next", 13'h0006, cmd_len_out)
      acc(1'b0, 12'h000, 3'h4, 32'h0, 2'b01, 32'h0, "reception read");
      acc(1'b1, 12'h000, 3'h1, 32'h0, 2'b01, 32'h0, "base rewrite");
      `CHK("len rewrite", 13'h0001, cmd_len_out)
      req(LCH, LAUNCH_CLEAR);
      st(CRBSC_RECEPTION, "launch zero");
      req(LCH, LAUNCH_GO);
      st(CRBSC_EXECUTION, "execution");
      `CHK("launch set", LAUNCH_GO, launch_field_out)
      `CHK("run", 1'b1, cmd_run_out)
      wait_st(CRBSC_COMPLETE);
      `CHK("launch cleared", LAUNCH_CLEAR, launch_field_out)
      `CHK("engine read", RESP, eng_rdata_out)
      $display("test reception done");
      acc(1'b0, 12'h004, 3'h4, 32'h0, 2'b10, 32'h0, "first read off base");
      acc(1'b0, 12'h000, 3'h4, 32'h0, 2'b01, RESP, "base read");
      acc(1'b0, 12'h008, 3'h4, 32'h0, 2'b10, 32'h0, "gap read");
      acc(1'b1, 12'h000, 3'h4, 32'hFFFF_FFFF, 2'b01, 32'h0, "write on response");
      acc(1'b0, 12'h000, 3'h4, 32'h0, 2'b01, RESP, "reread base");
      req(GOI, 32'h0);
      st(CRBSC_IDLE, "go idle");
      $display("test response done");
      req(RDY, 32'h0);
      acc(1'b1, 12'h000, 3'h2, 32'h0, 2'b01, 32'h0, "cancel cmd write");
      req(ABT, ABORT_GO);
      `CHK("cancel outside", 1'b0, cmd_cancel_out)
      `CHK("abort field", ABORT_GO, abort_command_field_out)
      req(LCH, LAUNCH_GO);
      `CHK("cancel inside", 1'b1, cmd_cancel_out)
      wait_st(CRBSC_COMPLETE);
      acc(1'b0, 12'h000, 3'h4, 32'h0, 2'b01, RESP_CAN, "cancel response");
      req(ABT, 32'h0);
      req(LOC, 32'h0);
      st(CRBSC_IDLE, "locality");
      $display("test cancel done");
      req(RDY, 32'h0);
      acc(1'b1, 12'h000, 3'h1, 32'h0, 2'b01, 32'h0, "abandon write");
      req(GOI, 32'h0);
      st(CRBSC_IDLE, "abandon");
      $display("test abandon done");
      req(RDY, 32'h0);
      @(posedge clock_in);
      cmd_fatal_in <= 1'b1;
      @(posedge clock_in);
      cmd_fatal_in <= 1'b0;
      rst_in       <= 1'b1;
      #1;
      `CHK("fatal set", 1'b1, fatal_error_flag_out)
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      #1;
      st(CRBSC_IDLE, "mid reset");
      `CHK("mid reset fatal", FATAL_RESET, fatal_error_flag_out)
      $display("test reset done");
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clock_in);
      n_fail++;
      end_sim();
   end
endmodule

// [common/crbsc_pkg.sv]
// Shared constants and types of the command buffer state control block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package crbsc_pkg;

   // ************************************************************
   // Buffer geometry
   // ************************************************************
   localparam int unsigned BUF_BYTES = 4096;
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned PTR_W     = 13;
   localparam int unsigned SIZE_W    = 3;
   localparam logic [ADDR_W-1:0] BUF_BASE = 12'h000;
   localparam logic [PTR_W-1:0]  BUF_END  = 13'h1000;

   // ************************************************************
   // Register values and reset values
   // ************************************************************
   localparam logic [31:0] LAUNCH_GO     = 32'h0000_0001;
   localparam logic [31:0] LAUNCH_CLEAR  = 32'h0000_0000;
   localparam logic [31:0] ABORT_GO      = 32'h0000_0001;
   localparam logic [31:0] LAUNCH_RESET  = 32'h0000_0000;
   localparam logic [31:0] ABORT_RESET   = 32'h0000_0000;
   localparam logic        IDLE_RESET    = 1'h1;
   localparam logic        FATAL_RESET   = 1'h0;

   // ************************************************************
   // Interface states, one-hot
   // ************************************************************
   typedef enum logic [4:0] {
      CRBSC_IDLE      = 5'h01,
      CRBSC_READY     = 5'h02,
      CRBSC_RECEPTION = 5'h04,
      CRBSC_EXECUTION = 5'h08,
      CRBSC_COMPLETE  = 5'h10
   } crbsc_state_e;

   // ************************************************************
   // One buffer access: size is a byte count of 1 to 4
   // ************************************************************
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [SIZE_W-1:0] size;
      logic [31:0]       wdata;
   } crbsc_acc_s;

   // Only 1, 2 or 4 bytes are legal transfer sizes
   function automatic logic crbsc_size_ok(input logic [SIZE_W-1:0] size);
      return (size == 3'h1) || (size == 3'h2) || (size == 3'h4);
   endfunction

   // Byte position just past an access
   function automatic logic [PTR_W-1:0] crbsc_next_ptr(input logic [ADDR_W-1:0] addr,
                                                        input logic [SIZE_W-1:0] size);
      return {1'b0, addr} + {{(PTR_W-SIZE_W){1'b0}}, size};
   endfunction

endpackage

// [rtl/crbsc_buffer.sv]
// Byte-wide command/response storage with one write port and two read ports.
// Assumes the caller only presents legal, in-range accesses.
`timescale 1ns/1ps
module crbsc_buffer
   import crbsc_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   // Write port
   input  wire logic              we_in,
   input  wire logic [ADDR_W-1:0] waddr_in,
   input  wire logic [SIZE_W-1:0] wsize_in,
   input  wire logic [31:0]       wdata_in,
   // Host read port, data reads as zero when not enabled
   input  wire logic              host_ren_in,
   input  wire logic [ADDR_W-1:0] host_raddr_in,
   output logic [31:0]            host_rdata_out,
   // Engine read port
   input  wire logic [ADDR_W-1:0] eng_raddr_in,
   output logic [31:0]            eng_rdata_out
);

   logic [7:0]  mem [0:BUF_BYTES-1];
   logic [31:0] host_rdata_d;
   logic [31:0] eng_rdata_d;

   always_comb begin
      host_rdata_d = 32'h0000_0000;
      eng_rdata_d  = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         if (host_ren_in) begin
            host_rdata_d[8*i +: 8] = mem[ADDR_W'(host_raddr_in + ADDR_W'(i))];
         end
         eng_rdata_d[8*i +: 8] = mem[ADDR_W'(eng_raddr_in + ADDR_W'(i))];
      end
   end

   // No reset on the array: contents are undefined until written
   always_ff @(posedge clock_in) begin
      if (we_in) begin
         for (int i = 0; i < 4; i++) begin
            if (SIZE_W'(i) < wsize_in) begin
               mem[ADDR_W'(waddr_in + ADDR_W'(i))] <= wdata_in[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         host_rdata_out <= 32'h0000_0000;
         eng_rdata_out  <= 32'h0000_0000;
      end else begin
         host_rdata_out <= host_rdata_d;
         eng_rdata_out  <= eng_rdata_d;
      end
   end

endmodule

// [rtl/crbsc_ctrl.sv]
// Interface state control of the buffer handoff interface, with buffer access checking.
// Assumes host requests come from bus logic on the same clock as one-cycle pulses,
// and a command engine that answers a run request with a done pulse.
`timescale 1ns/1ps
module crbsc_ctrl
   import crbsc_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   // Request control register writes, one-cycle pulses
   input  wire logic              ready_request_in,
   input  wire logic              idle_request_in,
   input  wire logic              locality_change_in,
   // Launch and abort register writes
   input  wire logic              launch_wr_in,
   input  wire logic [31:0]       launch_wdata_in,
   input  wire logic              abort_wr_in,
   input  wire logic [31:0]       abort_wdata_in,
   // Host buffer access
   input  wire crbsc_acc_s        host_acc_in,
   output logic                   host_ack_out,
   output logic                   host_err_out,
   output logic [31:0]            host_rdata_out,
   // Status
   output logic                   idle_status_flag_out,
   output logic                   fatal_error_flag_out,
   output logic [31:0]            launch_field_out,
   output logic [31:0]            abort_command_field_out,
   output crbsc_state_e           state_out,
   // Command engine
   output logic                   cmd_run_out,
   output logic                   cmd_cancel_out,
   output logic [PTR_W-1:0]       cmd_len_out,
   input  wire logic              cmd_done_in,
   input  wire logic              cmd_fatal_in,
   input  wire crbsc_acc_s        eng_acc_in,
   output logic [31:0]            eng_rdata_out
);

   // ************************************************************
   // State
   // ************************************************************
   crbsc_state_e     state_q, state_d;
   logic [31:0]      launch_q, launch_d;
   logic [31:0]      abort_q, abort_d;
   logic             idle_q, idle_d;
   logic             fatal_q, fatal_d;
   logic             run_q, run_d;
   logic             cancel_q, cancel_d;
   logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
   logic             wr_started_q, wr_started_d;
   logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
   logic             rd_started_q, rd_started_d;
   logic             ack_q, ack_d;
   logic             err_q, err_d;

   // ************************************************************
   // Access decode
   // ************************************************************
   logic             host_wr;
   logic             host_rd;
   logic             at_base;
   logic             size_ok;
   logic             in_range;
   logic             wr_ok;
   logic             rd_ok;
   logic             buf_we;
   logic [ADDR_W-1:0] buf_waddr;
   logic [SIZE_W-1:0] buf_wsize;
   logic [31:0]      buf_wdata;

   assign host_wr  = host_acc_in.valid && host_acc_in.write;
   assign host_rd  = host_acc_in.valid && !host_acc_in.write;
   assign at_base  = host_acc_in.addr == BUF_BASE;
   assign size_ok  = crbsc_size_ok(host_acc_in.size);
   assign in_range = crbsc_next_ptr(host_acc_in.addr, host_acc_in.size) <= BUF_END;

   // Writes only land while a command is being gathered
   assign wr_ok = host_wr && size_ok && in_range
                  && (state_q == CRBSC_READY || state_q == CRBSC_RECEPTION)
                  && (at_base
                      || (wr_started_q && {1'b0, host_acc_in.addr} == wr_ptr_q));

   // Reads only return data when a response is held
   assign rd_ok = host_rd && size_ok && in_range && state_q == CRBSC_COMPLETE
                  && (at_base
                      || (rd_started_q && {1'b0, host_acc_in.addr} == rd_ptr_q));

   // The engine owns the write port only while executing
   always_comb begin
      if (state_q == CRBSC_EXECUTION) begin
         buf_we    = eng_acc_in.valid && eng_acc_in.write
                     && crbsc_size_ok(eng_acc_in.size)
                     && crbsc_next_ptr(eng_acc_in.addr, eng_acc_in.size) <= BUF_END;
         buf_waddr = eng_acc_in.addr;
         buf_wsize = eng_acc_in.size;
         buf_wdata = eng_acc_in.wdata;
      end else begin
         buf_we    = wr_ok;
         buf_waddr = host_acc_in.addr;
         buf_wsize = host_acc_in.size;
         buf_wdata = host_acc_in.wdata;
      end
   end

   // ************************************************************
   // State transitions
   // ************************************************************
   always_comb begin
      state_d = state_q;
      launch_d = launch_q;
      if (locality_change_in) begin
         state_d  = CRBSC_IDLE;
         launch_d = LAUNCH_CLEAR;
      end else begin
         unique case (state_q)
            CRBSC_IDLE: begin
               if (ready_request_in) begin
                  state_d = CRBSC_READY;
               end
            end
            CRBSC_READY: begin
               if (idle_request_in) begin
                  state_d = CRBSC_IDLE;
               end else if (wr_ok && !ready_request_in) begin
                  state_d = CRBSC_RECEPTION;
               end
            end
            CRBSC_RECEPTION: begin
               if (idle_request_in) begin
                  state_d = CRBSC_IDLE;
               end else if (ready_request_in) begin
                  state_d = CRBSC_READY;
               end else if (launch_wr_in && launch_wdata_in == LAUNCH_GO) begin
                  state_d  = CRBSC_EXECUTION;
                  launch_d = LAUNCH_GO;
               end
            end
            CRBSC_EXECUTION: begin
               // Idle, ready and launch requests are ignored until the engine finishes
               if (cmd_done_in) begin
                  state_d  = CRBSC_COMPLETE;
                  launch_d = LAUNCH_CLEAR;
               end
            end
            CRBSC_COMPLETE: begin
               if (idle_request_in) begin
                  state_d = CRBSC_IDLE;
               end else if (ready_request_in) begin
                  state_d = CRBSC_READY;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Status and engine controls
   // ************************************************************
   always_comb begin
      abort_d  = abort_wr_in ? abort_wdata_in : abort_q;
      idle_d   = state_d == CRBSC_IDLE;
      run_d    = state_d == CRBSC_EXECUTION;
      // Cancel reaches the engine only while executing; it must still finish with done
      cancel_d = run_d && abort_d == ABORT_GO;
      // Sticky until reset; reset wins over a set in the same cycle
      fatal_d  = fatal_q || cmd_fatal_in;
   end

   // ************************************************************
   // Buffer pointers
   // ************************************************************
   always_comb begin
      wr_ptr_d     = wr_ptr_q;
      wr_started_d = wr_started_q;
      rd_ptr_d     = rd_ptr_q;
      rd_started_d = rd_started_q;
      if (wr_ok) begin
         // A base write throws away everything gathered so far
         wr_ptr_d     = crbsc_next_ptr(host_acc_in.addr, host_acc_in.size);
         wr_started_d = 1'b1;
      end
      if (rd_ok) begin
         rd_ptr_d     = crbsc_next_ptr(host_acc_in.addr, host_acc_in.size);
         rd_started_d = 1'b1;
      end
      if (state_d == CRBSC_IDLE || state_d == CRBSC_READY) begin
         wr_started_d = 1'b0;
      end
      if (state_d != CRBSC_COMPLETE) begin
         rd_started_d = 1'b0;
      end
   end

   // ************************************************************
   // Host answer: every access is answered one cycle later
   // ************************************************************
   always_comb begin
      ack_d = 1'b0;
      err_d = 1'b0;
      if (host_acc_in.valid) begin
         // Reads outside completion are answered with zero data
         if (host_rd && state_q == CRBSC_COMPLETE && !rd_ok) begin
            err_d = 1'b1;
         end else begin
            ack_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q      <= CRBSC_IDLE;
         launch_q     <= LAUNCH_RESET;
         abort_q      <= ABORT_RESET;
         idle_q       <= IDLE_RESET;
         fatal_q      <= FATAL_RESET;
         run_q        <= 1'b0;
         cancel_q     <= 1'b0;
         wr_ptr_q     <= '0;
         wr_started_q <= 1'b0;
         rd_ptr_q     <= '0;
         rd_started_q <= 1'b0;
         ack_q        <= 1'b0;
         err_q        <= 1'b0;
      end else begin
         state_q      <= state_d;
         launch_q     <= launch_d;
         abort_q      <= abort_d;
         idle_q       <= idle_d;
         fatal_q      <= fatal_d;
         run_q        <= run_d;
         cancel_q     <= cancel_d;
         wr_ptr_q     <= wr_ptr_d;
         wr_started_q <= wr_started_d;
         rd_ptr_q     <= rd_ptr_d;
         rd_started_q <= rd_started_d;
         ack_q        <= ack_d;
         err_q        <= err_d;
      end
   end

   // ************************************************************
   // Storage
   // ************************************************************
   // Sized for the largest command or response this design accepts
   crbsc_buffer u_buffer (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .we_in         (buf_we),
      .waddr_in      (buf_waddr),
      .wsize_in      (buf_wsize),
      .wdata_in      (buf_wdata),
      .host_ren_in   (rd_ok),
      .host_raddr_in (host_acc_in.addr),
      .host_rdata_out(host_rdata_out),
      .eng_raddr_in  (eng_acc_in.addr),
      .eng_rdata_out (eng_rdata_out)
   );

   assign host_ack_out            = ack_q;
   assign host_err_out            = err_q;
   assign idle_status_flag_out    = idle_q;
   assign fatal_error_flag_out    = fatal_q;
   assign launch_field_out        = launch_q;
   assign abort_command_field_out = abort_q;
   assign state_out               = state_q;
   assign cmd_run_out             = run_q;
   assign cmd_cancel_out          = cancel_q;
   assign cmd_len_out             = wr_ptr_q;

endmodule
